// File: hdl/ocl_map.svh
// offsets, field positions, reset values and timing figures of the overcurrent block
`ifndef OCL_MAP_SVH
`define OCL_MAP_SVH
`define OCL_CMD_FAULT_LIM   8'h46
`define OCL_CMD_FAULT_ACT   8'h47
`define OCL_CMD_WARN_LIM    8'h4a
`define OCL_PHASE_ALL       8'hff
`define OCL_EXP_MSB         15
`define OCL_EXP_LSB         11
`define OCL_MAN_MSB         10
`define OCL_MAN_SIGN        10
`define OCL_EXP_QUARTER     5'h1e
`define OCL_FAULT_RST       16'hf080
`define OCL_WARN_RST        16'hf060
`define OCL_ACT_RST         8'hb8
`define OCL_ACT_MSB         7
`define OCL_ACT_LSB         6
`define OCL_RETRY_MSB       5
`define OCL_RETRY_LSB       3
`define OCL_DLY_MSB         2
`define OCL_DLY_LSB         0
`define OCL_Q_SHIFT         6
`define OCL_Q_SAT           16'hffff
`define OCL_MAX_PHASE_Q     16'd3968
`define OCL_GRID_SH         7
`define OCL_GRID_ROUND      16'd127
`define OCL_GRID_MIN        16'd4
`define OCL_GRID_TOP        16'd31
`define OCL_NVM_SH          4
`define OCL_NVM_ROUND       16'd8
`define OCL_NVM_MAX         16'd248
`define OCL_RETRY_NONE      3'h0
`define OCL_RETRY_FOREVER   3'h7
`define OCL_DLY_ONE_MAX     3'h1
`define OCL_DLY_THREE_MAX   3'h4
`define OCL_PWM_ONE         3'h1
`define OCL_PWM_THREE       3'h3
`define OCL_PWM_SEVEN       3'h7
`define OCL_TON_RISE_US     1000
`define OCL_CLK_MHZ         50
`endif

// File: hdl/ocl_pkg.sv
// types shared by the overcurrent limit and response logic
package ocl_pkg;
    typedef enum logic [2:0] {
        st_run     = 3'h0,
        st_delay   = 3'h1,
        st_hiccup  = 3'h3,
        st_restart = 3'h2,
        st_latch   = 3'h6
    } ocl_state_type;
    typedef enum logic [1:0] {
        act_ignore0   = 2'h0,
        act_ignore1   = 2'h1,
        act_delayed   = 2'h2,
        act_immediate = 2'h3
    } ocl_act_type;
endpackage : ocl_pkg

// File: hdl/ocl_resp_if.sv
// carrier between the command logic and the fault response sequencer
`timescale 1ns/1ps
interface ocl_resp_if;
    logic       fault_evt;
    logic       pwm_edge;
    logic [7:0] action_byte;
    logic       enable_cmd;
    logic       start_ok;
    logic       power_en;
    logic       latched;
    logic [2:0] retry_cnt;
    modport ctrl (output fault_evt, output pwm_edge, output action_byte, output enable_cmd, output start_ok,
                  input power_en, input latched, input retry_cnt);
    modport seq  (input fault_evt, input pwm_edge, input action_byte, input enable_cmd, input start_ok,
                  output power_en, output latched, output retry_cnt);
endinterface : ocl_resp_if

// File: hdl/ocl_resp_seq.sv
// overcurrent fault response: delay, shutdown, hiccup and retry sequencing
`timescale 1ns/1ps
`include "ocl_map.svh"
module ocl_resp_seq
    import ocl_pkg::*;
#(
    parameter int HICCUP_UNIT = `OCL_TON_RISE_US * `OCL_CLK_MHZ
) (
    input  wire logic ref_clk,
    input  wire logic rst_sync_b,
    ocl_resp_if.seq   rif
);
    typedef struct packed {
        ocl_state_type state;
        logic [2:0]    dly_cnt;
        logic [23:0]   hic_cnt;
        logic [2:0]    tries;
    } ocl_seq_type;

    ocl_seq_type seq_ff;
    ocl_seq_type nxt_seq;

    function automatic logic [2:0] pwm_cycles(input logic [2:0] code);
        if (code <= `OCL_DLY_ONE_MAX) begin
            return `OCL_PWM_ONE;
        end else if (code <= `OCL_DLY_THREE_MAX) begin
            return `OCL_PWM_THREE;
        end
        return `OCL_PWM_SEVEN;
    endfunction : pwm_cycles

    logic [2:0]  retry;
    logic [2:0]  dcode;
    logic [2:0]  mult;
    ocl_act_type act;
    logic        go_off;

    always_comb begin
        retry   = rif.action_byte[`OCL_RETRY_MSB:`OCL_RETRY_LSB];
        dcode   = rif.action_byte[`OCL_DLY_MSB:`OCL_DLY_LSB];
        act     = ocl_act_type'(rif.action_byte[`OCL_ACT_MSB:`OCL_ACT_LSB]);
        mult    = (dcode <= `OCL_DLY_ONE_MAX) ? 3'h1 : dcode;
        go_off  = 1'b0;
        nxt_seq = seq_ff;
        case (seq_ff.state)
            st_run: begin
                if (rif.fault_evt) begin
                    case (act)
                        act_delayed: begin
                            nxt_seq.state   = st_delay;
                            nxt_seq.dly_cnt = pwm_cycles(dcode);
                        end
                        act_immediate: go_off = 1'b1;
                        default: go_off = 1'b0;
                    endcase
                end
            end
            st_delay: begin
                if (rif.pwm_edge) begin
                    if (seq_ff.dly_cnt == 3'h1) begin
                        go_off = 1'b1;
                    end else begin
                        nxt_seq.dly_cnt = seq_ff.dly_cnt - 3'h1;
                    end
                end
            end
            st_hiccup: begin
                if (seq_ff.hic_cnt == 24'h0) begin
                    nxt_seq.state = st_restart;
                    if (seq_ff.tries != 3'h7) begin
                        nxt_seq.tries = seq_ff.tries + 3'h1;
                    end
                end else begin
                    nxt_seq.hic_cnt = seq_ff.hic_cnt - 24'h1;
                end
            end
            st_restart: begin
                if (rif.fault_evt) begin
                    go_off = 1'b1;
                end else if (rif.start_ok) begin
                    nxt_seq.state = st_run;
                    nxt_seq.tries = 3'h0;
                end
            end
            default: nxt_seq.state = st_latch;
        endcase
        if (go_off) begin
            if (retry == `OCL_RETRY_NONE ||
                (retry != `OCL_RETRY_FOREVER && seq_ff.tries >= retry)) begin
                nxt_seq.state = st_latch;
            end else begin
                nxt_seq.state   = st_hiccup;
                nxt_seq.hic_cnt = 24'(HICCUP_UNIT * 32'(mult) - 1);
            end
        end
        if (!rif.enable_cmd) begin
            nxt_seq.state = st_run;
            nxt_seq.tries = 3'h0;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            seq_ff <= '{state: st_run, dly_cnt: 3'h0, hic_cnt: 24'h0, tries: 3'h0};
        end else begin
            seq_ff <= nxt_seq;
        end
    end

    assign rif.power_en  = rif.enable_cmd && (seq_ff.state == st_run || seq_ff.state == st_delay ||
                                              seq_ff.state == st_restart);
    assign rif.latched   = (seq_ff.state == st_latch);
    assign rif.retry_cnt = seq_ff.tries;
endmodule : ocl_resp_seq

// File: hdl/ocl_top.sv
// overcurrent fault and warning limit commands with fault response
// What this block does
// - limits are linear words, exponent resets minus two
// - stack limit is lowest phase limit times phases (code reads phase zero limit times phases)
// - hardware fault limit 8 A to 62 A, 2 A steps
// - between grid points use next higher value
// - below 8 A stored, comparator uses 8 A
// - restored values round to nearest quarter amp
// - all-phases write divides value by phase count
// - all-phases read returns phase zero times count
// - single phase access touches only that phase
// - unsupported values flag invalid data, alert host
// - fault sets overcurrent, current, fault bits, alert
// - action 00/01 ignore, 10 delayed, 11 immediate
// - retry 0 latch, 1-6 counted, 7 forever
// - delay code sets shutdown cycles and hiccup
// - each phase detects its own warning
// - warning sets other, current, warning bits, alert
// - warning limit up to 62 A times phases
// - fault limit 62 A per phase, times phases all
// - defaults load from nonvolatile store, updates immediate
// - limits are word commands, action a byte
`timescale 1ns/1ps
`include "ocl_map.svh"
module ocl_top
    import ocl_pkg::*;
#(
    parameter int NUM_PHASES  = 2,
    parameter int HICCUP_UNIT = `OCL_TON_RISE_US * `OCL_CLK_MHZ
) (
    input  wire logic                      ref_clk,
    input  wire logic                      rst_b,
    input  wire logic                      cmd_valid,
    input  wire logic                      cmd_write,
    input  wire logic                      cmd_word,
    input  wire logic [7:0]                cmd_code,
    input  wire logic [15:0]               cmd_wdata,
    input  wire logic [7:0]                phase_sel,
    output logic [15:0]                    cmd_rdata,
    output logic                           cmd_rvalid,
    output logic                           cmd_hit,
    input  wire logic                      nvm_load,
    input  wire logic [15:0]               nvm_fault_word,
    input  wire logic [15:0]               nvm_warn_word,
    input  wire logic [7:0]                nvm_action_byte,
    input  wire logic [NUM_PHASES-1:0]     oc_fault_cmp,
    input  wire logic [NUM_PHASES-1:0]     oc_warn_cmp,
    input  wire logic                      pwm_clk,
    input  wire logic                      enable_cmd,
    input  wire logic                      start_ok,
    input  wire logic                      clear_faults,
    output logic [NUM_PHASES*5-1:0]        fault_hw_code,
    output logic [NUM_PHASES*5-1:0]        warn_hw_code,
    output logic                           power_en,
    output logic                           latched,
    output logic                           status_byte_iout_oc,
    output logic                           status_byte_none_above,
    output logic                           status_word_iout,
    output logic                           status_iout_ocf,
    output logic [NUM_PHASES-1:0]          status_iout_ocw,
    output logic                           status_cml_data,
    output logic                           alert_o,
    output logic                           alert_oe_b
);
    localparam int PH = NUM_PHASES;

    typedef struct packed {
        logic [PH-1:0][15:0] fault_w;
        logic [PH-1:0][15:0] warn_w;
        logic [7:0]          action;
        logic [PH-1:0]       fcmp_s1;
        logic [PH-1:0]       fcmp_s2;
        logic [PH-1:0]       wcmp_s1;
        logic [PH-1:0]       wcmp_s2;
        logic                fault_prev;
        logic                pwm_s1;
        logic                pwm_s2;
        logic                pwm_s3;
        logic                sb_iout_oc;
        logic                sb_none;
        logic                sw_iout;
        logic                si_ocf;
        logic [PH-1:0]       si_ocw;
        logic                cml_data;
        logic [15:0]         rdata;
        logic                rvalid;
        logic                hit;
        logic [PH-1:0][4:0]  fault_hw;
        logic [PH-1:0][4:0]  warn_hw;
    } ocl_regs_type;

    ocl_regs_type regs_ff;
    ocl_regs_type nxt_regs;
    logic [1:0]   rst_pipe_ff;
    logic         rst_sync_b;
    ocl_resp_if   rif ();

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_pipe_ff <= 2'h0;
        end else begin
            rst_pipe_ff <= {rst_pipe_ff[0], 1'b1};
        end
    end
    assign rst_sync_b = rst_pipe_ff[1];

    // linear word to amps in 1/64 A; bit 16 flags a negative value
    function automatic logic [16:0] lin_to_q(input logic [15:0] w);
        logic signed [6:0] sh;
        logic [31:0]       mag;
        sh  = 7'({{2{w[`OCL_EXP_MSB]}}, w[`OCL_EXP_MSB:`OCL_EXP_LSB]}) + 7'sd6;
        mag = 32'(w[`OCL_MAN_SIGN-1:0]);
        if (w[`OCL_MAN_SIGN]) begin
            return {1'b1, 16'h0};
        end
        if (sh > 7'sd15) begin
            mag = (mag == 32'h0) ? 32'h0 : 32'hffff_ffff;
        end else if (sh >= 7'sd0) begin
            mag = mag << sh;
        end else begin
            mag = mag >> (-sh);
        end
        if (mag > 32'(`OCL_Q_SAT)) begin
            return {1'b0, `OCL_Q_SAT};
        end
        return {1'b0, mag[15:0]};
    endfunction : lin_to_q

    // per phase amps onto the 2 A comparator grid
    function automatic logic [4:0] grid_code(input logic [15:0] q);
        logic [16:0] units;
        units = ({1'b0, q} + 17'(`OCL_GRID_ROUND)) >> `OCL_GRID_SH;
        if (units < 17'(`OCL_GRID_MIN)) begin
            return 5'h0;
        end else if (units > 17'(`OCL_GRID_TOP)) begin
            return 5'(`OCL_GRID_TOP - `OCL_GRID_MIN);
        end
        return 5'(units - 17'(`OCL_GRID_MIN));
    endfunction : grid_code

    // quarter amp word; round picks nearest, else rounds up
    function automatic logic [15:0] q_to_word(input logic [15:0] q, input logic nearest);
        logic [16:0] qa;
        qa = ({1'b0, q} + (nearest ? 17'(`OCL_NVM_ROUND) : 17'h0f)) >> `OCL_NVM_SH;
        if (qa > 17'(`OCL_NVM_MAX)) begin
            qa = 17'(`OCL_NVM_MAX);
        end
        return {`OCL_EXP_QUARTER, 11'(qa)};
    endfunction : q_to_word

    logic [16:0] wq;
    logic [15:0] ph_q;
    logic [15:0] lim_q;
    logic        all_sel;
    logic        ph_ok;
    logic        lim_cmd;
    logic        bad;
    logic [2:0]  ph_idx;
    logic [31:0] stack_q;
    logic        fault_any;
    logic        fault_evt;

    always_comb begin
        nxt_regs   = regs_ff;
        all_sel    = (phase_sel == `OCL_PHASE_ALL);
        ph_ok      = all_sel || (32'(phase_sel) < PH);
        ph_idx     = ph_ok && !all_sel ? 3'(phase_sel) : 3'h0;
        wq         = lin_to_q(cmd_wdata);
        lim_q      = all_sel ? 16'(32'(`OCL_MAX_PHASE_Q) * PH) : `OCL_MAX_PHASE_Q;
        ph_q       = all_sel ? 16'(32'(wq[15:0]) / PH) : wq[15:0];
        lim_cmd    = (cmd_code == `OCL_CMD_FAULT_LIM) || (cmd_code == `OCL_CMD_WARN_LIM);
        stack_q    = 32'h0;
        bad        = 1'b0;
        nxt_regs.rvalid = 1'b0;
        nxt_regs.hit    = 1'b0;

        // comparator and switching clock synchronisers
        nxt_regs.fcmp_s1 = oc_fault_cmp;
        nxt_regs.fcmp_s2 = regs_ff.fcmp_s1;
        nxt_regs.wcmp_s1 = oc_warn_cmp;
        nxt_regs.wcmp_s2 = regs_ff.wcmp_s1;
        nxt_regs.pwm_s1  = pwm_clk;
        nxt_regs.pwm_s2  = regs_ff.pwm_s1;
        nxt_regs.pwm_s3  = regs_ff.pwm_s2;

        if (cmd_valid && (lim_cmd || cmd_code == `OCL_CMD_FAULT_ACT)) begin
            nxt_regs.hit = 1'b1;
            if (cmd_word != lim_cmd) begin
                bad = 1'b1;
            end else if (cmd_write) begin
                if (lim_cmd && (!ph_ok || wq[16] || wq[15:0] > lim_q)) begin
                    bad = 1'b1;
                end else if (cmd_code == `OCL_CMD_FAULT_ACT) begin
                    nxt_regs.action = cmd_wdata[7:0];
                end else begin
                    for (int i = 0; i < PH; i++) begin
                        if (all_sel || ph_idx == 3'(i)) begin
                            if (cmd_code == `OCL_CMD_FAULT_LIM) begin
                                nxt_regs.fault_w[i] = all_sel ? q_to_word(ph_q, 1'b0) : cmd_wdata;
                            end else begin
                                nxt_regs.warn_w[i] = all_sel ? q_to_word(ph_q, 1'b0) : cmd_wdata;
                            end
                        end
                    end
                end
            end else if (!ph_ok && lim_cmd) begin
                bad = 1'b1;
            end else begin
                nxt_regs.rvalid = 1'b1;
                if (cmd_code == `OCL_CMD_FAULT_ACT) begin
                    nxt_regs.rdata = {8'h0, regs_ff.action};
                end else if (all_sel) begin
                    stack_q = 32'(lin_to_q(cmd_code == `OCL_CMD_FAULT_LIM ?
                                           regs_ff.fault_w[0] : regs_ff.warn_w[0]) & 17'h0ffff) * PH;
                    nxt_regs.rdata = {`OCL_EXP_QUARTER, 11'(stack_q >> `OCL_NVM_SH)};
                end else begin
                    nxt_regs.rdata = (cmd_code == `OCL_CMD_FAULT_LIM) ?
                                     regs_ff.fault_w[ph_idx] : regs_ff.warn_w[ph_idx];
                end
            end
        end

        if (nvm_load) begin
            for (int i = 0; i < PH; i++) begin
                nxt_regs.fault_w[i] = q_to_word(16'(lin_to_q(nvm_fault_word) & 17'h0ffff), 1'b1);
                nxt_regs.warn_w[i]  = q_to_word(16'(lin_to_q(nvm_warn_word) & 17'h0ffff), 1'b1);
            end
            nxt_regs.action = nvm_action_byte;
        end

        // comparator settings follow the stored words one clock later
        for (int i = 0; i < PH; i++) begin
            nxt_regs.fault_hw[i] = grid_code(16'(lin_to_q(regs_ff.fault_w[i]) & 17'h0ffff));
            nxt_regs.warn_hw[i]  = grid_code(16'(lin_to_q(regs_ff.warn_w[i]) & 17'h0ffff));
        end

        // stack trips on the first phase whose own limit is crossed
        fault_any           = |regs_ff.fcmp_s2;
        nxt_regs.fault_prev = fault_any;
        fault_evt           = fault_any && !regs_ff.fault_prev;

        if (clear_faults) begin
            nxt_regs.sb_iout_oc = 1'b0;
            nxt_regs.sb_none    = 1'b0;
            nxt_regs.sw_iout    = 1'b0;
            nxt_regs.si_ocf     = 1'b0;
            nxt_regs.si_ocw     = '0;
            nxt_regs.cml_data   = 1'b0;
        end
        // set wins over a clear in the same cycle
        if (fault_evt) begin
            nxt_regs.sb_iout_oc = 1'b1;
            nxt_regs.sw_iout    = 1'b1;
            nxt_regs.si_ocf     = 1'b1;
        end
        for (int i = 0; i < PH; i++) begin
            if (regs_ff.wcmp_s2[i]) begin
                nxt_regs.si_ocw[i] = 1'b1;
                nxt_regs.sb_none   = 1'b1;
                nxt_regs.sw_iout   = 1'b1;
            end
        end
        if (bad) begin
            nxt_regs.cml_data = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            regs_ff         <= '0;
            regs_ff.fault_w <= {PH{`OCL_FAULT_RST}};
            regs_ff.warn_w  <= {PH{`OCL_WARN_RST}};
            regs_ff.action  <= `OCL_ACT_RST;
        end else begin
            regs_ff <= nxt_regs;
        end
    end

    assign rif.fault_evt   = fault_evt;
    assign rif.pwm_edge    = regs_ff.pwm_s2 && !regs_ff.pwm_s3;
    assign rif.action_byte = regs_ff.action;
    assign rif.enable_cmd  = enable_cmd;
    assign rif.start_ok    = start_ok;

    ocl_resp_seq #(
        .HICCUP_UNIT (HICCUP_UNIT)
    ) u_seq (
        .ref_clk    (ref_clk),
        .rst_sync_b (rst_sync_b),
        .rif        (rif.seq)
    );

    assign cmd_rdata              = regs_ff.rdata;
    assign cmd_rvalid             = regs_ff.rvalid;
    assign cmd_hit                = regs_ff.hit;
    assign fault_hw_code          = regs_ff.fault_hw;
    assign warn_hw_code           = regs_ff.warn_hw;
    assign power_en               = rif.power_en;
    assign latched                = rif.latched;
    assign status_byte_iout_oc    = regs_ff.sb_iout_oc;
    assign status_byte_none_above = regs_ff.sb_none;
    assign status_word_iout       = regs_ff.sw_iout;
    assign status_iout_ocf        = regs_ff.si_ocf;
    assign status_iout_ocw        = regs_ff.si_ocw;
    assign status_cml_data        = regs_ff.cml_data;
    // open-drain alert: pin pulled low while any flag stands
    assign alert_o                = 1'b0;
    assign alert_oe_b             = !(regs_ff.sb_iout_oc || regs_ff.sb_none || regs_ff.cml_data);
endmodule : ocl_top

// File: test/ocl_host.sv
// host side model: command transfers and switching clock
`timescale 1ns/1ps
module ocl_host (
    input  wire logic        ref_clk,
    input  wire logic [15:0] cmd_rdata,
    input  wire logic        cmd_rvalid,
    input  wire logic        cmd_hit,
    output logic             cmd_valid,
    output logic             cmd_write,
    output logic             cmd_word,
    output logic [7:0]       cmd_code,
    output logic [15:0]      cmd_wdata,
    output logic [7:0]       phase_sel,
    output logic             pwm_clk
);
    initial {cmd_valid, cmd_write, cmd_word, cmd_code, cmd_wdata, phase_sel, pwm_clk} = '0;
    always #80 pwm_clk = ~pwm_clk;
    task automatic xfer(input logic w, input logic wd, input logic [7:0] c, input logic [15:0] d,
                        input logic [7:0] p, output logic h, output logic [15:0] rd);
        @(posedge ref_clk);
        #1;
        cmd_valid = 1'b1;
        cmd_write = w;
        cmd_word  = wd;
        cmd_code  = c;
        cmd_wdata = d;
        phase_sel = p;
        @(posedge ref_clk);
        #1;
        cmd_valid = 1'b0;
        cmd_code  = ~c;
        cmd_wdata = ~d;
        h  = cmd_hit;
        rd = (cmd_rvalid === 1'b1) ? cmd_rdata : 16'hxxxx;
    endtask : xfer
endmodule : ocl_host

// File: test/ocl_top_checker.sv
// assertions on the overcurrent block ports
`timescale 1ns/1ps
module ocl_top_checker #(
    parameter int NUM_PHASES = 2
) (
    input wire logic                  ref_clk,
    input wire logic                  rst_b,
    input wire logic                  cmd_valid,
    input wire logic                  cmd_write,
    input wire logic [7:0]            cmd_code,
    input wire logic                  cmd_hit,
    input wire logic                  cmd_rvalid,
    input wire logic [NUM_PHASES-1:0] oc_warn_cmp,
    input wire logic [NUM_PHASES*5-1:0] fault_hw_code,
    input wire logic                  power_en,
    input wire logic                  latched,
    input wire logic                  status_byte_iout_oc,
    input wire logic                  status_byte_none_above,
    input wire logic                  status_word_iout,
    input wire logic                  status_iout_ocf,
    input wire logic [NUM_PHASES-1:0] status_iout_ocw,
    input wire logic                  status_cml_data,
    input wire logic                  alert_oe_b
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    logic known;
    assign known = cmd_code == 8'h46 || cmd_code == 8'h47 || cmd_code == 8'h4a;
    property p_hit; cmd_valid && known |=> cmd_hit; endproperty
    a_hit: assert property (p_hit) else $error("no hit after command");
    property p_miss; cmd_valid && !known |=> !cmd_hit; endproperty
    a_miss: assert property (p_miss) else $error("hit on unknown code");
    property p_rdv; cmd_rvalid |-> $past(cmd_valid && !cmd_write && known); endproperty
    a_rdv: assert property (p_rdv) else $error("read data without read");
    property p_alert; $rose(status_cml_data) || $rose(status_iout_ocf) |-> ##[0:1] !alert_oe_b; endproperty
    a_alert: assert property (p_alert) else $error("alert not driven");
    property p_flt; $rose(status_iout_ocf) |-> status_byte_iout_oc && status_word_iout; endproperty
    a_flt: assert property (p_flt) else $error("fault status bits apart");
    property p_wrn; $rose(status_iout_ocw[0]) |-> status_byte_none_above && status_word_iout; endproperty
    a_wrn: assert property (p_wrn) else $error("warning status bits apart");
    property p_wset; $rose(oc_warn_cmp[0]) ##1 oc_warn_cmp[0] [*3] |=> status_iout_ocw[0]; endproperty
    a_wset: assert property (p_wset) else $error("warning not flagged");
    property p_grid; fault_hw_code[4:0] <= 5'd27; endproperty
    a_grid: assert property (p_grid) else $error("fault code above top");
    property p_latch; latched |-> !power_en; endproperty
    a_latch: assert property (p_latch) else $error("power on while latched");
endmodule : ocl_top_checker
bind ocl_top ocl_top_checker #(.NUM_PHASES(NUM_PHASES)) u_ocl_top_checker (.*);

// File: test/overcurrent_limit_response_test.sv
// self-checking bench for the overcurrent limit and response block
`timescale 1ns/1ps
module overcurrent_limit_response_test;
    logic        ref_clk = 1'b0, rst_b = 1'b0, enable_cmd = 1'b0, clear_faults = 1'b0;
    logic        nvm_load = 1'b0, start_ok = 1'b0;
    logic [7:0]  nvm_action_byte = 8'h00;
    logic [15:0] nvm_fault_word = 16'h0000, nvm_warn_word = 16'h0000;
    logic [1:0]  oc_fault_cmp = 2'h0, oc_warn_cmp = 2'h0, status_iout_ocw;
    logic        cmd_valid, cmd_write, cmd_word, pwm_clk, cmd_rvalid, cmd_hit, power_en, latched, h;
    logic        status_byte_iout_oc, status_byte_none_above, status_word_iout, status_iout_ocf;
    logic        status_cml_data, alert_o, alert_oe_b;
    logic [7:0]  cmd_code, phase_sel;
    logic [15:0] cmd_wdata, cmd_rdata, rd;
    logic [9:0]  fault_hw_code, warn_hw_code;
    int          bad_count = 0, n_compared = 0, i;
    always #10 ref_clk = ~ref_clk;
    ocl_top #(.NUM_PHASES(2), .HICCUP_UNIT(20)) u_ocl_top (.*);
    ocl_host u_ocl_host (.*);
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic conclude();
        if (bad_count == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : conclude
    task automatic wr(input logic wd, input logic [7:0] c, input logic [15:0] d, input logic [7:0] p);
        u_ocl_host.xfer(1'b1, wd, c, d, p, h, rd);
        @(posedge ref_clk);
        #1;
    endtask : wr
    task automatic rdc(input logic wd, input logic [7:0] c, input logic [7:0] p, input logic [15:0] exp);
        u_ocl_host.xfer(1'b0, wd, c, 16'h0000, p, h, rd);
        check(rd, exp);
    endtask : rdc
    task automatic clr();
        repeat (3) @(posedge ref_clk);
        #1;
        clear_faults = 1'b1;
        @(posedge ref_clk);
        #1;
        clear_faults = 1'b0;
        @(posedge ref_clk);
        #1;
        check(status_cml_data | status_iout_ocf | status_word_iout, 16'h0000);
        check(alert_oe_b, 16'h0001);
    endtask : clr
    task automatic t_reset();
        check(fault_hw_code, {5'd12, 5'd12});
        check(warn_hw_code, {5'd8, 5'd8});
        rdc(1'b1, 8'h46, 8'h00, 16'hf080);
        rdc(1'b1, 8'h4a, 8'h01, 16'hf060);
        rdc(1'b0, 8'h47, 8'h00, 16'h00b8);
    endtask : t_reset
    task automatic t_phase();
        wr(1'b1, 8'h46, 16'hf024, 8'h01);
        check(fault_hw_code, {5'd1, 5'd12});
        wr(1'b1, 8'h46, 16'hf010, 8'h00);
        check(fault_hw_code, {5'd1, 5'd0});
        rdc(1'b1, 8'h46, 8'h00, 16'hf010);
        wr(1'b1, 8'h46, 16'hf0a0, 8'hff);
        check(fault_hw_code, {5'd6, 5'd6});
        rdc(1'b1, 8'h46, 8'hff, 16'hf0a0);
        wr(1'b1, 8'h46, 16'hf1f0, 8'hff);
        check(fault_hw_code, {5'd27, 5'd27});
        wr(1'b1, 8'h4a, 16'hf1f0, 8'hff);
        wr(1'b1, 8'h4a, 16'hf044, 8'h00);
        check(warn_hw_code, {5'd27, 5'd5});
    endtask : t_phase
    task automatic t_bad();
        wr(1'b1, 8'h46, 16'hf0fc, 8'h00);
        check(status_cml_data, 16'h0001);
        check(alert_oe_b, 16'h0000);
        check(fault_hw_code, {5'd27, 5'd27});
        wr(1'b1, 8'h47, 16'h00c0, 8'h00);
        rdc(1'b0, 8'h47, 8'h00, 16'h00b8);
        u_ocl_host.xfer(1'b0, 1'b1, 8'h48, 16'h0000, 8'h00, h, rd);
        check(h, 16'h0000);
        clr();
    endtask : t_bad
    task automatic t_warn();
        oc_warn_cmp = 2'h2;
        repeat (4) @(posedge ref_clk);
        #1;
        check(status_iout_ocw, 16'h0002);
        check({status_byte_none_above, status_word_iout, status_iout_ocf}, 16'h0006);
        check(alert_oe_b, 16'h0000);
        oc_warn_cmp = 2'h0;
        clr();
    endtask : t_warn
    task automatic t_fault();
        wr(1'b0, 8'h47, 16'h00c0, 8'h00);
        enable_cmd = 1'b1;
        @(posedge ref_clk);
        #1;
        check(power_en, 16'h0001);
        oc_fault_cmp = 2'h2;
        for (i = 0; i < 30 && latched !== 1'b1; i++) @(posedge ref_clk);
        if (i == 30) begin
            bad_count++;
            conclude();
        end
        #1;
        check({latched, power_en}, 16'h0002);
        check({status_byte_iout_oc, status_word_iout, status_iout_ocf}, 16'h0007);
        oc_fault_cmp = 2'h0;
        enable_cmd = 1'b0;
        @(posedge ref_clk);
        #1;
        check(latched, 16'h0000);
    endtask : t_fault
    initial begin
        repeat (10) @(posedge ref_clk);
        #1;
        rst_b = 1'b1;
        repeat (3) @(posedge ref_clk);
        #1;
        t_reset();
        t_phase();
        t_bad();
        t_warn();
        t_fault();
        conclude();
    end
endmodule : overcurrent_limit_response_test
